// file: shared/pcc_pkg.sv
// Shared constants and types for the PLL setup and clock interrupt block.
package pcc_pkg;
  // Bus widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_WAIT = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_DIV1 = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_DIV2 = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_DBG = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_IEN = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_CLR = 4'h6;
  // Writable-bit masks; all other bits are reserved and read zero
  localparam logic [DATA_W-1:0] WAIT_MASK = 8'h17;
  localparam logic [DATA_W-1:0] DIV1_MASK = 8'hff;
  localparam logic [DATA_W-1:0] DIV2_MASK = 8'h3f;
  localparam logic [DATA_W-1:0] DBG_MASK = 8'ha0;
  localparam logic [DATA_W-1:0] EVT_MASK = 8'h27;
  // Reset values
  localparam logic [DATA_W-1:0] RST_REG = 8'h00;
  localparam logic [4:0] RST_RATIO16 = 5'h01;
  localparam logic [6:0] RST_RATIO64 = 7'h01;
  // Field positions
  localparam int REF_SEL_BIT = 4;
  localparam int WAIT_CODE_LSB = 0;
  localparam int WAIT_CODE_W = 3;
  localparam int REF_DIV_LSB = 4;
  localparam int VCO_DIV_LSB = 0;
  localparam int DIV4_W = 4;
  localparam int FB_DIV_LSB = 0;
  localparam int FB_DIV_W = 6;
  localparam int HARDWARE_WATCHDOG_BIT = 7;
  localparam int SOFTWARE_WATCHDOG_BIT = 5;
  // Event positions in status, clear and enable registers
  localparam int EV_FREQ = 5;
  localparam int EV_PLL = 2;
  localparam int EV_SUB = 1;
  localparam int EV_MAIN = 0;
  // PLL wait is 2^(WAIT_EXP_BASE + code) fast RC periods
  localparam int WAIT_EXP_BASE = 9;
  localparam int WAIT_CNT_W = 17;
  // PLL wait timer states
  typedef enum logic [1:0] {
    PCC_W_IDLE = 2'b00,
    PCC_W_COUNT = 2'b01,
    PCC_W_DONE = 2'b10
  } pcc_wait_st_t;
endpackage : pcc_pkg

// file: verilog/pcc_pll_wait_timer.sv
// PLL stabilization wait timer counting fast RC clock ticks.
`timescale 1ns/100ps
module pcc_pll_wait_timer
  import pcc_pkg::*;
(
  // Clock and resets
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  // Control
  input wire logic osc_on_i,
  input wire logic rc_tick_i,
  input wire logic [WAIT_CODE_W-1:0] code_i,
  // Result
  output logic ready_o,
  output logic done_o
);
  typedef struct packed {
    pcc_wait_st_t st;
    logic [WAIT_CNT_W-1:0] cnt;
    logic ready;
    logic done;
  } pcc_wait_q_t;

  pcc_wait_q_t q_q, q_d;

  // Tick count that ends a wait for a given code
  function automatic logic [WAIT_CNT_W-1:0] wait_limit(input logic [WAIT_CODE_W-1:0] c);
    wait_limit = WAIT_CNT_W'(1) << (WAIT_EXP_BASE + int'(c));
  endfunction : wait_limit

  // Next-state logic
  always_comb begin
    q_d = q_q;
    q_d.done = 1'b0;
    case (q_q.st)
      PCC_W_IDLE: begin
        q_d.cnt = '0;
        q_d.ready = 1'b0;
        if (osc_on_i) begin
          q_d.st = PCC_W_COUNT;
        end
      end
      PCC_W_COUNT: begin
        if (!osc_on_i) begin
          q_d.st = PCC_W_IDLE;
        // [R2] Wait of 2^(9+code) ticks
        // [R4] Code read live, so a change mid-wait shifts the end
        end else if (rc_tick_i) begin
          if (q_q.cnt == wait_limit(code_i) - WAIT_CNT_W'(1)) begin
            q_d.st = PCC_W_DONE;
            q_d.ready = 1'b1;
            q_d.done = 1'b1;
          end else begin
            q_d.cnt = q_q.cnt + WAIT_CNT_W'(1);
          end
        end
      end
      PCC_W_DONE: begin
        // Oscillator off drops readiness
        if (!osc_on_i) begin
          q_d.st = PCC_W_IDLE;
          q_d.ready = 1'b0;
        end
      end
      default: begin
        q_d.st = PCC_W_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || soft_rst_i) begin
      q_q <= '{st: PCC_W_IDLE, cnt: '0, ready: 1'b0, done: 1'b0};
    end else begin
      q_q <= q_d;
    end
  end

  assign ready_o = q_q.ready;
  assign done_o = q_q.done;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i || soft_rst_i);

  // Last tick of 2^(9+code) must end the wait on the next edge
  wait_end_a: assert property ( // [R2]
    q_q.st == PCC_W_COUNT && osc_on_i && rc_tick_i &&
      q_q.cnt == (WAIT_CNT_W'(1) << (WAIT_EXP_BASE + code_i)) - WAIT_CNT_W'(1)
      |=> done_o && ready_o)
    else $error("PLL wait ended at wrong count");
endmodule : pcc_pll_wait_timer

// file: verilog/pcc_event_status.sv
// Sticky clock event status bits with set-over-clear priority.
`timescale 1ns/100ps
module pcc_event_status
  import pcc_pkg::*;
#(
  parameter int W = DATA_W,
  parameter logic [W-1:0] MASK = EVT_MASK
) (
  // Clock and resets
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  // Events and clears
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  // Status
  output logic [W-1:0] stat_o
);
  typedef struct packed {
    logic [W-1:0] stat;
  } pcc_stat_q_t;

  pcc_stat_q_t q_q, q_d;

  // Set wins over a clear in the same cycle
  always_comb begin
    q_d = q_q;
    q_d.stat = MASK & (set_i | (q_q.stat & ~clr_i));
  end

  // Status register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || soft_rst_i) begin
      q_q <= '0;
    end else begin
      q_q <= q_d;
    end
  end

  assign stat_o = q_q.stat;
endmodule : pcc_event_status

// file: verilog/pcc_clock_setup.sv
// PLL setup registers, watchdog break control and clock event interrupts.
`timescale 1ns/100ps
// Functional notes
// [R1] Reference select: 0 main osc, 1 fast RC
// [R2] Wait code gives 2^(9+code) RC periods
// [R3] Software sets wait before PLL enable
// [R4] Wait change mid-wait is not guaranteed
// [R5] Reserved bits read zero, written zero
// [R6] Input divider ratio is field plus one
// [R7] VCO divider ratio is field plus one
// [R8] Feedback divider ratio is field plus one
// [R9] Software sets dividers before PLL enable
// [R10] Dividers, debug register survive software reset
// [R11] Hardware watchdog halts in break unless enabled
// [R12] Software watchdog halts in break unless enabled
// [R13] Frequency anomaly interrupt gated by enable
// [R14] PLL ready interrupt gated by enable
// [R15] Sub oscillator interrupt gated by enable
// [R16] Main oscillator interrupt gated by enable
// [R17] Status shows each event once occurred
// [R18] Clear register write-one clears, reads zero
// [R19] Interrupt while enabled status bit set
module pcc_clock_setup
  import pcc_pkg::*;
(
  // Clock and resets
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [DATA_W-1:0] rdata_o,
  // Clock unit status and events
  input wire logic pll_osc_on_i,
  input wire logic fast_rc_tick_i,
  input wire logic main_osc_ready_i,
  input wire logic sub_osc_ready_i,
  input wire logic freq_anomaly_i,
  input wire logic debug_halt_i,
  // PLL configuration
  output logic pll_ref_select_o,
  output logic [DIV4_W:0] ref_div_ratio_o,
  output logic [DIV4_W:0] vco_div_ratio_o,
  output logic [FB_DIV_W:0] fb_div_ratio_o,
  output logic pll_ready_o,
  // Watchdog count enables
  output logic hardware_watchdog_count_en_o,
  output logic software_watchdog_count_en_o,
  // Interrupt
  output logic irq_o
);
  // All block state except pll_ready_q and the submodule state
  typedef struct packed {
    logic [DATA_W-1:0] wait_src;
    logic [DATA_W-1:0] div1;
    logic [DATA_W-1:0] div2;
    logic [DATA_W-1:0] dbg;
    logic [DATA_W-1:0] ien;
    logic [DATA_W-1:0] rdata;
    logic [DIV4_W:0] ref_ratio;
    logic [DIV4_W:0] vco_ratio;
    logic [FB_DIV_W:0] fb_ratio;
    logic hw_run;
    logic sw_run;
    logic irq;
  } pcc_state_t;

  pcc_state_t q_q, q_d;

  // Timer outputs, status set and clear vectors, status output
  logic pll_done;
  logic pll_ready;
  logic [DATA_W-1:0] ev_set;
  logic [DATA_W-1:0] ev_clr;
  logic [DATA_W-1:0] stat;

  // Write decode, shared by every register
  function automatic logic wr_hit(input logic we, input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] reg_a);
    wr_hit = we && (a == reg_a);
  endfunction : wr_hit

  // PLL stabilization wait timer
  pcc_pll_wait_timer u_wait (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .soft_rst_i(soft_rst_i),
    .osc_on_i(pll_osc_on_i),
    .rc_tick_i(fast_rc_tick_i),
    .code_i(q_q.wait_src[WAIT_CODE_LSB +: WAIT_CODE_W]),
    .ready_o(pll_ready),
    .done_o(pll_done)
  );

  // [R17] Event vector in status layout
  always_comb begin
    ev_set = '0;
    ev_set[EV_FREQ] = freq_anomaly_i;
    ev_set[EV_PLL] = pll_done;
    ev_set[EV_SUB] = sub_osc_ready_i;
    ev_set[EV_MAIN] = main_osc_ready_i;
  end

  // [R18] Clears from clear register or status read
  always_comb begin
    ev_clr = '0;
    if (wr_hit(wr_en_i, addr_i, ADDR_CLR)) begin
      ev_clr = wdata_i;
    end else if (rd_en_i && addr_i == ADDR_STAT) begin
      // Reading status acknowledges everything it showed
      ev_clr = EVT_MASK;
    end
  end

  // Sticky event status
  pcc_event_status #(
    .W(DATA_W),
    .MASK(EVT_MASK)
  ) u_stat (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .soft_rst_i(soft_rst_i),
    .set_i(ev_set),
    .clr_i(ev_clr),
    .stat_o(stat)
  );

  // Next-state logic for registers and outputs
  always_comb begin
    q_d = q_q;
    // [R5] Reserved bits never stored
    if (wr_hit(wr_en_i, addr_i, ADDR_WAIT)) begin
      q_d.wait_src = wdata_i & WAIT_MASK;
    end
    if (wr_hit(wr_en_i, addr_i, ADDR_DIV1)) begin
      q_d.div1 = wdata_i & DIV1_MASK;
    end
    if (wr_hit(wr_en_i, addr_i, ADDR_DIV2)) begin
      q_d.div2 = wdata_i & DIV2_MASK;
    end
    if (wr_hit(wr_en_i, addr_i, ADDR_DBG)) begin
      q_d.dbg = wdata_i & DBG_MASK;
    end
    if (wr_hit(wr_en_i, addr_i, ADDR_IEN)) begin
      q_d.ien = wdata_i & EVT_MASK;
    end
    // [R6] Input divider ratio
    q_d.ref_ratio = {1'b0, q_q.div1[REF_DIV_LSB +: DIV4_W]} + RST_RATIO16;
    // [R7] VCO divider ratio
    q_d.vco_ratio = {1'b0, q_q.div1[VCO_DIV_LSB +: DIV4_W]} + RST_RATIO16;
    // [R8] Feedback divider ratio
    q_d.fb_ratio = {1'b0, q_q.div2[FB_DIV_LSB +: FB_DIV_W]} + RST_RATIO64;
    // [R11] Hardware watchdog break behaviour
    q_d.hw_run = !debug_halt_i || q_q.dbg[HARDWARE_WATCHDOG_BIT];
    // [R12] Software watchdog break behaviour
    q_d.sw_run = !debug_halt_i || q_q.dbg[SOFTWARE_WATCHDOG_BIT];
    // [R13] [R14] [R15] [R16] Per-event enable gating
    // [R19] Any enabled pending event raises the line
    q_d.irq = |(stat & q_q.ien);
    // Read data stand one cycle only
    q_d.rdata = '0;
    if (rd_en_i) begin
      // [R5] Unused bits and unmapped addresses read zero
      case (addr_i)
        ADDR_WAIT: begin
          q_d.rdata = q_q.wait_src;
        end
        ADDR_DIV1: begin
          q_d.rdata = q_q.div1;
        end
        ADDR_DIV2: begin
          q_d.rdata = q_q.div2;
        end
        ADDR_DBG: begin
          q_d.rdata = q_q.dbg;
        end
        ADDR_IEN: begin
          q_d.rdata = q_q.ien;
        end
        ADDR_STAT: begin
          q_d.rdata = stat;
        end
        // Clear register is write-only and reads zero
        default: begin
          q_d.rdata = '0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q_q <= '{wait_src: RST_REG, div1: RST_REG, div2: RST_REG, dbg: RST_REG,
               ien: RST_REG, rdata: RST_REG, ref_ratio: RST_RATIO16,
               vco_ratio: RST_RATIO16, fb_ratio: RST_RATIO64,
               hw_run: 1'b1, sw_run: 1'b1, irq: 1'b0};
    end else if (soft_rst_i) begin
      // [R10] Soft reset spares dividers and debug control
      q_q <= q_d;
      q_q.wait_src <= RST_REG;
      q_q.ien <= RST_REG;
      q_q.irq <= 1'b0;
      q_q.rdata <= RST_REG;
    end else begin
      q_q <= q_d;
    end
  end

  // Ready flag registered once more so every output leaves a flop here
  logic pll_ready_q;

  // PLL ready output stage
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || soft_rst_i) begin
      pll_ready_q <= 1'b0;
    end else begin
      pll_ready_q <= pll_ready;
    end
  end

  // [R1] Reference select bit drives the PLL input mux
  assign pll_ref_select_o = q_q.wait_src[REF_SEL_BIT];
  assign ref_div_ratio_o = q_q.ref_ratio;
  assign vco_div_ratio_o = q_q.vco_ratio;
  assign fb_div_ratio_o = q_q.fb_ratio;
  assign hardware_watchdog_count_en_o = q_q.hw_run;
  assign software_watchdog_count_en_o = q_q.sw_run;
  assign irq_o = q_q.irq;
  assign rdata_o = q_q.rdata;
  assign pll_ready_o = pll_ready_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Reference select follows a write
  ref_sel_a: assert property ( // [R1]
    wr_en_i && addr_i == ADDR_WAIT && !soft_rst_i |=>
      pll_ref_select_o == $past(wdata_i[REF_SEL_BIT]))
    else $error("Reference select did not follow write");

  // Reserved bits read back as zero
  rsvd_zero_a: assert property ( // [R5]
    rd_en_i && addr_i == ADDR_WAIT |=> (rdata_o & ~WAIT_MASK) == '0)
    else $error("Reserved bits read nonzero");

  // Input divider ratio two cycles after write
  ref_div_a: assert property ( // [R6]
    wr_en_i && addr_i == ADDR_DIV1 ##1 !wr_en_i |=>
      ref_div_ratio_o == {1'b0, $past(wdata_i[REF_DIV_LSB +: DIV4_W], 2)} + RST_RATIO16)
    else $error("Input divider ratio wrong");

  // VCO divider ratio two cycles after write
  vco_div_a: assert property ( // [R7]
    wr_en_i && addr_i == ADDR_DIV1 ##1 !wr_en_i |=>
      vco_div_ratio_o == {1'b0, $past(wdata_i[VCO_DIV_LSB +: DIV4_W], 2)} + RST_RATIO16)
    else $error("VCO divider ratio wrong");

  // Feedback divider ratio two cycles after write
  fb_div_a: assert property ( // [R8]
    wr_en_i && addr_i == ADDR_DIV2 ##1 !wr_en_i |=>
      fb_div_ratio_o == {1'b0, $past(wdata_i[FB_DIV_LSB +: FB_DIV_W], 2)} + RST_RATIO64)
    else $error("Feedback divider ratio wrong");

  // Divider and debug contents kept through soft reset
  soft_keep_a: assert property ( // [R10]
    soft_rst_i && !wr_en_i |=> q_q.div1 == $past(q_q.div1) &&
      q_q.div2 == $past(q_q.div2) && q_q.dbg == $past(q_q.dbg))
    else $error("Soft reset disturbed kept registers");

  // Hardware watchdog stops in break by default
  hardware_watchdog_a: assert property ( // [R11]
    debug_halt_i && !q_q.dbg[HARDWARE_WATCHDOG_BIT] |=> !hardware_watchdog_count_en_o)
    else $error("Hardware watchdog ran in break");

  // Software watchdog stops in break by default
  software_watchdog_a: assert property ( // [R12]
    debug_halt_i && !q_q.dbg[SOFTWARE_WATCHDOG_BIT] |=> !software_watchdog_count_en_o)
    else $error("Software watchdog ran in break");

  // Event reaches status next cycle
  main_set_a: assert property ( // [R17]
    main_osc_ready_i && !soft_rst_i |=> stat[EV_MAIN])
    else $error("Main oscillator event not latched");

  // Write-one clear takes effect
  clr_main_a: assert property ( // [R18]
    wr_en_i && addr_i == ADDR_CLR && wdata_i[EV_MAIN] && !main_osc_ready_i |=>
      !stat[EV_MAIN])
    else $error("Clear did not clear status");

  // Interrupt tracks enabled pending status
  irq_gate_a: assert property ( // [R19]
    !soft_rst_i && !$past(soft_rst_i) |-> irq_o == $past(|(stat & q_q.ien)))
    else $error("Interrupt mismatches enabled status");

  // PLL event gated by its enable
  pll_mask_a: assert property ( // [R14]
    stat == 8'h04 && !q_q.ien[EV_PLL] && !soft_rst_i |=> !irq_o)
    else $error("Disabled PLL event raised interrupt");

  irq_rise_c: cover property ($rose(irq_o));
  pll_ready_c: cover property ($rose(pll_ready_o));
  stat_read_c: cover property (rd_en_i && addr_i == ADDR_STAT && stat != '0);
  brk_run_c: cover property (debug_halt_i && q_q.dbg[HARDWARE_WATCHDOG_BIT]);
endmodule : pcc_clock_setup

// file: dv/pcc_clock_setup_test.sv
// Self-checking bench for the PLL setup and clock event interrupt block.
`timescale 1ns/100ps
module pcc_clock_setup_test;
  import pcc_pkg::*;

  // Clock, resets and register port
  logic clk_sys_i;
  logic rst_i;
  logic soft_rst_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic wr_en_i;
  logic rd_en_i;
  logic [DATA_W-1:0] rdata_o;
  // Clock unit inputs; events share one vector indexed by status position
  logic pll_osc_on_i;
  logic fast_rc_tick_i;
  logic [7:0] ev;
  logic debug_halt_i;
  // Observed outputs
  logic pll_ref_select_o;
  logic [DIV4_W:0] ref_div_ratio_o;
  logic [DIV4_W:0] vco_div_ratio_o;
  logic [FB_DIV_W:0] fb_div_ratio_o;
  logic pll_ready_o;
  logic hardware_watchdog_count_en_o;
  logic software_watchdog_count_en_o;
  logic irq_o;
  // Bench bookkeeping
  int mismatches = 0;
  int num_checks = 0;
  logic [7:0] sh [0:4];
  logic [7:0] mk [0:4];
  logic [3:0] a;
  logic [7:0] d;
  int evb [0:2];

  pcc_clock_setup pcc_clock_setup_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .rdata_o(rdata_o), .pll_osc_on_i(pll_osc_on_i), .fast_rc_tick_i(fast_rc_tick_i),
    .main_osc_ready_i(ev[EV_MAIN]), .sub_osc_ready_i(ev[EV_SUB]),
    .freq_anomaly_i(ev[EV_FREQ]), .debug_halt_i(debug_halt_i),
    .pll_ref_select_o(pll_ref_select_o), .ref_div_ratio_o(ref_div_ratio_o),
    .vco_div_ratio_o(vco_div_ratio_o), .fb_div_ratio_o(fb_div_ratio_o),
    .pll_ready_o(pll_ready_o), .hardware_watchdog_count_en_o(hardware_watchdog_count_en_o),
    .software_watchdog_count_en_o(software_watchdog_count_en_o), .irq_o(irq_o)
  );

  // 50 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // Verdict and end of run, shared with the watchdog
  task automatic final_report();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // Single comparison point
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t ns value %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write strobe, released on the next edge
  task automatic wr(input logic [3:0] ad, input logic [7:0] dv);
    @(posedge clk_sys_i);
    addr_i <= ad;
    wdata_i <= dv;
    wr_en_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_en_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [3:0] ad, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr_i <= ad;
    rd_en_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_en_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rd

  // Configuration outputs against the shadow copy of the registers
  task automatic chk_out();
    chk({7'h00, pll_ref_select_o}, {7'h00, sh[0][REF_SEL_BIT]});
    chk({3'h0, ref_div_ratio_o}, {4'h0, sh[1][7:4]} + 8'h01);
    chk({3'h0, vco_div_ratio_o}, {4'h0, sh[1][3:0]} + 8'h01);
    chk({1'b0, fb_div_ratio_o}, {2'h0, sh[2][5:0]} + 8'h01);
  endtask : chk_out

  // Event input high for exactly one sampled edge
  task automatic pulse(input int b);
    @(posedge clk_sys_i);
    ev[b] <= 1'b1;
    @(posedge clk_sys_i);
    ev[b] <= 1'b0;
  endtask : pulse

  // Hold the fast RC tick high for k sampled edges
  task automatic ticks(input int k);
    @(posedge clk_sys_i);
    fast_rc_tick_i <= 1'b1;
    repeat (k) @(posedge clk_sys_i);
    fast_rc_tick_i <= 1'b0;
  endtask : ticks

  // Hang guard, sized well above the longest sequence
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    mismatches++;
    final_report();
  end

  // Main sequence
  initial begin
    rst_i = 1'b1;
    soft_rst_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    wr_en_i = 1'b0;
    rd_en_i = 1'b0;
    pll_osc_on_i = 1'b0;
    fast_rc_tick_i = 1'b0;
    ev = '0;
    debug_halt_i = 1'b0;
    sh = '{default: 8'h00};
    mk = '{WAIT_MASK, DIV1_MASK, DIV2_MASK, DBG_MASK, EVT_MASK};
    evb = '{EV_MAIN, EV_SUB, EV_FREQ};
    void'($urandom(89));
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // Every address reads zero out of reset, unmapped ones included
    for (int i = 0; i < 16; i++) rd(i[3:0], 8'h00);
    chk_out();
    chk({6'h00, hardware_watchdog_count_en_o, software_watchdog_count_en_o}, 8'h03);
    // Unmapped and clear addresses swallow writes; clear gets only its own bits
    for (int i = 6; i < 16; i++) begin
      wr(i[3:0], (i == 6) ? EVT_MASK : 8'hff);
      rd(i[3:0], 8'h00);
    end
    // All-ones corner first, then random traffic over the five registers
    for (int i = 0; i < 40; i++) begin
      a = (i < 5) ? i[3:0] : 4'($urandom_range(4, 0));
      // Software keeps reserved bits zero on write
      d = ((i < 5) ? 8'hff : 8'($urandom)) & mk[a];
      wr(a, d);
      sh[a] = d;
      rd(a, sh[a]);
      chk_out();
    end
    // Software reset keeps dividers and debug control only
    @(posedge clk_sys_i);
    soft_rst_i <= 1'b1;
    @(posedge clk_sys_i);
    soft_rst_i <= 1'b0;
    sh[0] = 8'h00;
    sh[4] = 8'h00;
    for (int i = 0; i < 5; i++) rd(i[3:0], sh[i]);
    chk_out();
    // Watchdog behaviour under tool break for all four settings
    @(posedge clk_sys_i);
    debug_halt_i <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_DBG, {k[1], 1'b0, k[0], 5'h00});
      repeat (2) @(posedge clk_sys_i);
      #1 chk({7'h00, hardware_watchdog_count_en_o}, {7'h00, k[1]});
      chk({7'h00, software_watchdog_count_en_o}, {7'h00, k[0]});
    end
    // Break released on an edge, both watchdogs run again
    @(posedge clk_sys_i);
    debug_halt_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 chk({6'h00, hardware_watchdog_count_en_o, software_watchdog_count_en_o}, 8'h03);
    // Main, sub and frequency events with enable off then on; clear by read or by write
    foreach (evb[j]) begin
      for (int en = 0; en < 2; en++) begin
        wr(ADDR_IEN, en[0] ? (8'h01 << evb[j]) : 8'h00);
        pulse(evb[j]);
        repeat (2) @(posedge clk_sys_i);
        #1 chk({7'h00, irq_o}, {7'h00, en[0]});
        wr(ADDR_CLR, 8'h00);
        rd(ADDR_CLR, 8'h00);
        chk({7'h00, irq_o}, {7'h00, en[0]});
        if (en == 1) begin
          wr(ADDR_CLR, 8'h01 << evb[j]);
        end else begin
          rd(ADDR_STAT, 8'h01 << evb[j]);
        end
        rd(ADDR_STAT, 8'h00);
        chk({7'h00, irq_o}, 8'h00);
      end
    end
    // PLL wait: one tick short stays not ready, the last tick completes it
    for (int c = 0; c < 2; c++) begin
      // Wait code and dividers settled before enable
      wr(ADDR_WAIT, {3'h0, c[0], 1'b0, c[2:0]});
      sh[0] = {3'h0, c[0], 1'b0, c[2:0]};
      wr(ADDR_IEN, c[0] ? 8'h00 : 8'h04);
      chk_out();
      @(posedge clk_sys_i);
      pll_osc_on_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      // Wait code left alone while the wait runs
      ticks((1 << (WAIT_EXP_BASE + c)) - 1);
      repeat (4) @(posedge clk_sys_i);
      #1 chk({7'h00, pll_ready_o}, 8'h00);
      ticks(1);
      repeat (4) @(posedge clk_sys_i);
      #1 chk({7'h00, pll_ready_o}, 8'h01);
      chk({7'h00, irq_o}, {7'h00, ~c[0]});
      rd(ADDR_STAT, 8'h04);
      @(posedge clk_sys_i);
      pll_osc_on_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
    end
    final_report();
  end
endmodule : pcc_clock_setup_test
